// ==== logic/motor_pwm_compare_reload.sv ====
// 16-bit pwm timer with buffered compares and three reload modes
// assumes an apb master on clk and synchronous event and trigger pins
module motor_pwm_compare_reload
  import pwm_pkg::*;
(
  input wire logic clk,
  input wire logic reset_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic event_count_pin,
  input wire logic trigger_pin,
  output logic phase_one_output,
  output logic phase_two_output,
  output logic phase_three_output,
  output logic adc_trigger_a,
  output logic adc_trigger_b,
  output logic irq
);
  // ****************************************************************
  // state
  // ****************************************************************
  typedef struct packed {
    logic [15:0] cnt;
    logic [NBUF-1:0][15:0] buffer;
    logic [NBUF-1:0][15:0] active;
    logic pending;
    logic [2:0] ctrl;
    logic [7:0] edge_sel;
    logic [2:0] status;
    logic [2:0] mask;
    logic [15:0] events;
    logic evt_prev;
    logic trig_prev;
    logic [31:0] rdata;
    logic ready;
    logic slverr;
    logic [2:0] ph;
    logic adc_a;
    logic adc_b;
    logic irq;
  } pwm_state_t;
  pwm_state_t s_q, s_d;

  thin_if thin ();

  // ****************************************************************
  // helpers
  // ****************************************************************
  // map a byte offset to a buffered slot; valid flag in the top bit
  function automatic logic [3:0] buf_slot(input logic [7:0] a);
    unique case (a)
      OFS_CYCLE: buf_slot = {1'b1, IDX_CYCLE};
      OFS_DUTY_U: buf_slot = {1'b1, IDX_DUTY_U};
      OFS_DUTY_V: buf_slot = {1'b1, IDX_DUTY_V};
      OFS_DUTY_W: buf_slot = {1'b1, IDX_DUTY_W};
      OFS_THIN: buf_slot = {1'b1, IDX_THIN};
      OFS_ADC_A: buf_slot = {1'b1, IDX_ADC_A};
      OFS_ADC_B: buf_slot = {1'b1, IDX_ADC_B};
      default: buf_slot = 4'h0;
    endcase
  endfunction

  // true when the pin moved in the direction the two-bit field picks
  function automatic logic edge_hit(input logic [1:0] sel,
                                    input logic prev, input logic now);
    unique case (sel)
      EDGE_NONE: edge_hit = 1'b0;
      EDGE_RISE: edge_hit = now & ~prev;
      EDGE_FALL: edge_hit = prev & ~now;
      EDGE_BOTH: edge_hit = now ^ prev;
    endcase
  endfunction

  logic [3:0] slot;
  logic setup_rd;
  logic commit;
  logic wr;
  logic hit_addr;
  logic [31:0] rd_val;
  logic run;
  logic crest;
  logic valley;
  logic anytime;
  logic culled;
  logic xfer_time;
  logic xfer;
  logic wr_u;
  logic [2:0] ev;
  logic [15:0] cycle_v;

  // ****************************************************************
  // bus decode
  // ****************************************************************
  // one wait state: data is prepared on the first access edge and the
  // write lands on the edge where pready is seen high
  always_comb begin
    slot = buf_slot(paddr);
    setup_rd = psel & penable & ~s_q.ready;
    commit = psel & penable & s_q.ready;
    wr = commit & pwrite;
    hit_addr = 1'b1;
    rd_val = 32'h0000_0000;
    if (slot[3]) begin
      rd_val = {16'h0000, s_q.buffer[slot[2:0]]};
    end else begin
      unique case (paddr)
        OFS_CTRL: rd_val = {29'h0, s_q.ctrl};
        OFS_EDGE: rd_val = {24'h0, s_q.edge_sel};
        OFS_STATUS: rd_val = {29'h0, s_q.status};
        OFS_MASK: rd_val = {29'h0, s_q.mask};
        OFS_COUNT: rd_val = {16'h0000, s_q.cnt};
        OFS_EVENTS: rd_val = {16'h0000, s_q.events};
        default: hit_addr = 1'b0;
      endcase
    end
  end

  // ****************************************************************
  // counter, modes and transfer timing
  // ****************************************************************
  always_comb begin
    run = s_q.ctrl[CTRL_RUN];
    anytime = s_q.ctrl[CTRL_ANYTIME];
    cycle_v = s_q.active[IDX_CYCLE];
    crest = run & (s_q.cnt == cycle_v);
    valley = run & (s_q.cnt == VALLEY_POINT);
    // reload enable is only looked at when anytime write is clear
    culled = ~anytime & s_q.ctrl[CTRL_RELOAD];
    thin.crest = crest;
    thin.valley = valley;
    thin.count = s_q.active[IDX_THIN][THIN_CNT_MSB:THIN_CNT_LSB];
    thin.crest_en = s_q.active[IDX_THIN][THIN_CREST_EN];
    thin.valley_en = s_q.active[IDX_THIN][THIN_VALLEY_EN];
    // a nonzero thinning count with reload enable 0 behaves as plain
    // batch; interrupts are still culled, only transfers are not
    if (culled) begin
      xfer_time = thin.cull_crest | thin.cull_valley;
    end else begin
      xfer_time = crest | valley;
    end
    xfer = ~anytime & s_q.pending & xfer_time;
    wr_u = wr & slot[3] & (slot[2:0] == IDX_DUTY_U);
    ev = '0;
    ev[ST_CREST] = thin.cull_crest;
    ev[ST_VALLEY] = thin.cull_valley;
    ev[ST_XFER] = xfer;
  end

  pwm_thinner u_thinner (
    .clk(clk),
    .reset_n(reset_n),
    .t(thin.thinner)
  );

  // ****************************************************************
  // next state
  // ****************************************************************
  always_comb begin
    s_d = s_q;
    // period is cycle value plus one: count 0..cycle then wrap
    if (run) begin
      if (s_q.cnt >= cycle_v) begin
        s_d.cnt = 16'h0000;
      end else begin
        s_d.cnt = s_q.cnt + 16'h0001;
      end
    end
    // selected trigger edge restarts the period
    if (edge_hit(s_q.edge_sel[EDGE_TRIG_LSB+1:EDGE_TRIG_LSB],
                 s_q.trig_prev, trigger_pin)) begin
      s_d.cnt = 16'h0000;
    end
    s_d.trig_prev = trigger_pin;
    s_d.evt_prev = event_count_pin;
    if (edge_hit(s_q.edge_sel[EDGE_EVT_LSB+1:EDGE_EVT_LSB],
                 s_q.evt_prev, event_count_pin)) begin
      s_d.events = s_q.events + 16'h0001;
    end
    // batch load copies all seven shadows together
    if (xfer) begin
      s_d.active = s_q.buffer;
    end
    // new u duty write in the transfer cycle re-arms, so it is not lost
    s_d.pending = (s_q.pending & ~xfer) | (wr_u & ~anytime);
    // bus writes; the shadow keeps only the last value written
    if (wr) begin
      if (slot[3]) begin
        s_d.buffer[slot[2:0]] = pwdata[15:0];
        if (anytime) begin
          s_d.active[slot[2:0]] = pwdata[15:0];
        end
      end else begin
        unique case (paddr)
          OFS_CTRL: s_d.ctrl = pwdata[2:0];
          OFS_EDGE: s_d.edge_sel = pwdata[7:0];
          OFS_MASK: s_d.mask = pwdata[2:0];
          OFS_EVENTS: s_d.events = pwdata[15:0];
          default: s_d.slverr = s_q.slverr;
        endcase
      end
    end
    // sticky status: read clears only what was shown, new events win
    s_d.status = s_q.status;
    if (commit & ~pwrite & (paddr == OFS_STATUS)) begin
      s_d.status = s_q.status & ~s_q.rdata[2:0];
    end
    s_d.status = s_d.status | ev;
    s_d.irq = |(s_d.status & s_q.mask);
    // apb answer
    s_d.ready = setup_rd;
    if (setup_rd) begin
      s_d.rdata = pwrite ? 32'h0000_0000 : rd_val;
      s_d.slverr = ~hit_addr;
    end else begin
      s_d.rdata = 32'h0000_0000;
      s_d.slverr = 1'b0;
    end
    // phase outputs active while the count is below each duty value
    for (int i = 0; i < 3; i++) begin
      s_d.ph[i] = run & (s_d.cnt < s_d.active[IDX_DUTY_U + 3'(i)]);
    end
    s_d.adc_a = crest & 1'b0 | (run & (s_q.cnt == s_q.active[IDX_ADC_A]));
    s_d.adc_b = run & (s_q.cnt == s_q.active[IDX_ADC_B]);
  end

  // ****************************************************************
  // registers
  // ****************************************************************
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign prdata = s_q.rdata;
  assign pready = s_q.ready;
  assign pslverr = s_q.slverr;
  assign phase_one_output = s_q.ph[0];
  assign phase_two_output = s_q.ph[1];
  assign phase_three_output = s_q.ph[2];
  assign adc_trigger_a = s_q.adc_a;
  assign adc_trigger_b = s_q.adc_b;
  assign irq = s_q.irq;
endmodule

// ==== logic/pwm_pkg.sv ====
// constants, register map and field layout of the motor pwm compare block
// assumes one 100 MHz clock and an apb master with 32-bit data
// Notes on behaviour
// - seven registers have a shadow buffer in front of the active copy.
// - with anytime write set, writes land at once and reload enable is moot.
// - batch mode is anytime write 0 and reload enable 0, with any thinning count.
// - in batch modes a phase u duty write arms a transfer of all seven.
// - writes to the other six alone never arm a transfer.
// - plain batch mode transfers at the next crest or valley after a transfer is armed.
// - culled batch mode is anytime write 0 with reload enable 1.
// - culled batch mode transfers only at culled crest or valley events.
// - two two-bit fields pick the valid edge of the event and trigger pins.
package pwm_pkg;
  // ****************************************************************
  // register byte offsets
  // ****************************************************************
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_CYCLE = 8'h04;
  localparam logic [7:0] OFS_DUTY_U = 8'h08;
  localparam logic [7:0] OFS_DUTY_V = 8'h0c;
  localparam logic [7:0] OFS_DUTY_W = 8'h10;
  localparam logic [7:0] OFS_THIN = 8'h14;
  localparam logic [7:0] OFS_ADC_A = 8'h18;
  localparam logic [7:0] OFS_ADC_B = 8'h1c;
  localparam logic [7:0] OFS_EDGE = 8'h20;
  localparam logic [7:0] OFS_STATUS = 8'h24;
  localparam logic [7:0] OFS_MASK = 8'h28;
  localparam logic [7:0] OFS_COUNT = 8'h2c;
  localparam logic [7:0] OFS_EVENTS = 8'h30;
  // ****************************************************************
  // buffered register slots
  // ****************************************************************
  localparam int NBUF = 7;
  localparam logic [2:0] IDX_CYCLE = 3'h0;
  localparam logic [2:0] IDX_DUTY_U = 3'h1;
  localparam logic [2:0] IDX_DUTY_V = 3'h2;
  localparam logic [2:0] IDX_DUTY_W = 3'h3;
  localparam logic [2:0] IDX_THIN = 3'h4;
  localparam logic [2:0] IDX_ADC_A = 3'h5;
  localparam logic [2:0] IDX_ADC_B = 3'h6;
  // ****************************************************************
  // field positions
  // ****************************************************************
  localparam int CTRL_RUN = 0;
  localparam int CTRL_ANYTIME = 1;
  localparam int CTRL_RELOAD = 2;
  localparam int THIN_CNT_LSB = 0;
  localparam int THIN_CNT_MSB = 4;
  localparam int THIN_CREST_EN = 5;
  localparam int THIN_VALLEY_EN = 6;
  localparam int EDGE_TRIG_LSB = 0;
  localparam int EDGE_EVT_LSB = 2;
  localparam int ST_CREST = 0;
  localparam int ST_VALLEY = 1;
  localparam int ST_XFER = 2;
  // ****************************************************************
  // reset values and fixed compare points
  // ****************************************************************
  localparam logic [15:0] RST_REG16 = 16'h0000;
  localparam logic [2:0] RST_CTRL = 3'h0;
  localparam logic [7:0] RST_EDGE = 8'h00;
  localparam logic [2:0] RST_IRQ = 3'h0;
  localparam logic [15:0] VALLEY_POINT = 16'h0001;
  localparam logic [4:0] THIN_NONE = 5'h00;
  // edge select encodings
  localparam logic [1:0] EDGE_NONE = 2'h0;
  localparam logic [1:0] EDGE_RISE = 2'h1;
  localparam logic [1:0] EDGE_FALL = 2'h2;
  localparam logic [1:0] EDGE_BOTH = 2'h3;
endpackage

// ==== logic/pwm_thinner.sv ====
// interrupt culling: passes one of every count+1 enabled crest or valley
// assumes events are single-cycle and arrive on clk
module pwm_thinner
  import pwm_pkg::*;
(
  input wire logic clk,
  input wire logic reset_n,
  thin_if.thinner t
);
  typedef struct packed {
    logic [4:0] seen;
  } thin_state_t;
  thin_state_t s_q, s_d;
  logic hit;

  // an enabled event either passes (count reached) or is only counted
  always_comb begin
    s_d = s_q;
    hit = (t.crest & t.crest_en) | (t.valley & t.valley_en);
    if (hit) begin
      if (s_q.seen >= t.count) begin
        s_d.seen = THIN_NONE;
      end else begin
        s_d.seen = s_q.seen + 5'h01;
      end
    end
  end

  assign t.cull_crest = t.crest & t.crest_en & (s_q.seen >= t.count);
  assign t.cull_valley = t.valley & t.valley_en & (s_q.seen >= t.count);

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end
endmodule

// ==== logic/thin_if.sv ====
// carries crest and valley events to the thinning unit and back
// assumes both ends sit on the same clock
interface thin_if;
  logic crest;
  logic valley;
  logic [4:0] count;
  logic crest_en;
  logic valley_en;
  logic cull_crest;
  logic cull_valley;
  modport timer (output crest, valley, count, crest_en, valley_en,
                 input cull_crest, cull_valley);
  modport thinner (input crest, valley, count, crest_en, valley_en,
                   output cull_crest, cull_valley);
endinterface

// ==== test/gate_driver_model.sv ====
// gate driver model: counts how long each phase gate is driven on
// assumes active-high phase outputs registered on clk
module gate_driver_model (
  input wire logic clk,
  input wire logic clear,
  input wire logic gate_u,
  input wire logic gate_v,
  input wire logic gate_w,
  output int unsigned on_u,
  output int unsigned on_v,
  output int unsigned on_w
);
  timeunit 1ns;
  timeprecision 100ps;
  // on-time counters; a window that spans whole periods needs no phase
  always_ff @(posedge clk) begin
    on_u <= clear ? 0 : on_u + gate_u;
    on_v <= clear ? 0 : on_v + gate_v;
    on_w <= clear ? 0 : on_w + gate_w;
  end
endmodule

// ==== test/pwm_asserts.sv ====
// checker for the apb answer timing and the adc_trigger_a output of the pwm block
// assumes one clock domain and a bind onto the top module
module pwm_asserts (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic adc_trigger_a,
  input wire logic phase_one_output,
  input wire logic irq
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  // ****
  // bus answer: one wait state, answer stands one cycle
  // ****
  a_ready_single: assert property (pready |=> !pready)
    else $error("pready held longer than one cycle");
  a_ready_waits_one: assert property (psel && penable && !pready |=> pready)
    else $error("no answer one cycle after access");
  a_ready_needs_access: assert property (!(psel && penable) |=> !pready)
    else $error("answer without an access cycle");
  a_data_idle_zero: assert property (!pready |-> prdata == 32'h0)
    else $error("read data not zero outside answer");
  a_err_with_ready: assert property (pslverr |-> pready)
    else $error("error flag without answer");
  a_err_data_zero: assert property (pslverr |-> prdata == 32'h0)
    else $error("refused access returned data");
  a_upper_zero: assert property (pready && !pwrite |-> prdata[31:16] == 16'h0)
    else $error("upper half of a read not zero");
  // a trigger is a one-cycle match pulse while the cycle is above zero
  a_trig_pulse: assert property (adc_trigger_a |=> !adc_trigger_a)
    else $error("trigger pulse longer than one cycle");
  cover property (pslverr);
  cover property ($rose(phase_one_output));
  cover property ($rose(irq));
endmodule
bind motor_pwm_compare_reload pwm_asserts chk (.clk, .reset_n, .psel,
  .penable, .pwrite, .prdata, .pready, .pslverr, .adc_trigger_a,
  .phase_one_output, .irq);

// ==== test/test_motor_pwm_compare_reload.sv ====
// bench for the pwm block: register table, rewrite modes, edge codes
// assumes the gate driver model and the bound checker are compiled first
module test_motor_pwm_compare_reload import pwm_pkg::*;;
  timeunit 1ns;
  timeprecision 100ps;
  typedef struct {logic [7:0] a; logic [31:0] d, x; logic er;} row_t;
  logic clk = 0, reset_n = 0, psel = 0, penable = 0, pwrite = 0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, evt = 0, trg = 0, clear = 0, e, ph1, ph2, ph3, irq;
  int unsigned on_u, on_v, on_w, na, nb;
  logic adc_a, adc_b;
  int err_count = 0, samples_checked = 0, n;
  logic [31:0] ev_x[4] = '{32'h0, 32'h3, 32'h3, 32'h6};
  row_t rows[8] = '{'{OFS_CYCLE, 32'h12345, 32'h2345, 0},
    '{OFS_DUTY_U, 32'hffff, 32'hffff, 0}, '{OFS_DUTY_V, 32'haa, 32'haa, 0},
    '{OFS_DUTY_W, 32'h55, 32'h55, 0}, '{OFS_ADC_A, 32'h3, 32'h3, 0},
    '{OFS_ADC_B, 32'h4, 32'h4, 0}, '{OFS_EDGE, 32'h10f, 32'h0f, 0},
    '{8'h40, 32'h1, 32'h0, 1}};
  motor_pwm_compare_reload uut (.clk, .reset_n, .psel, .penable, .pwrite,
    .paddr, .pwdata, .prdata, .pready, .pslverr, .event_count_pin(evt),
    .trigger_pin(trg), .phase_one_output(ph1), .phase_two_output(ph2),
    .phase_three_output(ph3), .adc_trigger_a(adc_a), .adc_trigger_b(adc_b),
    .irq);
  gate_driver_model drv (.clk, .clear, .gate_u(ph1), .gate_v(ph2),
    .gate_w(ph3), .on_u, .on_v, .on_w);
  always #5 clk = ~clk;
  // trigger pulse counters share the gate model's measuring window
  always @(posedge clk) begin
    na <= clear ? 0 : na + adc_a;
    nb <= clear ? 0 : nb + adc_b;
  end
  // ****
  // tasks: every call starts and ends on a rising edge
  // ****
  task automatic cyc(input int k);
    repeat (k) @(posedge clk);
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic summarize();
    $display("checks %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // setup waits one edge so a release never meets a new request
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge clk);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1;
    do begin
      @(posedge clk);
      k++;
    end while (pready !== 1'b1 && k < 50);
    rd = prdata;
    e = pslverr;
    psel <= 0;
    penable <= 0;
    if (k >= 50) begin
      err_count++;
      $display("CHECK FAILED at %0t: no answer", $time);
      summarize();
    end
  endtask
  // window of k cycles, a whole number of periods
  task automatic meas(input int k, input logic [31:0] u, v, w);
    clear <= 1;
    cyc(1);
    clear <= 0;
    cyc(k + 1);
    chk(on_u, u);
    chk(on_v, v);
    chk(on_w, w);
  endtask
  // ****
  // main sequence
  // ****
  initial begin
    cyc(3);
    reset_n <= 1;
    apb(0, OFS_CYCLE, 0);
    chk(rd, 32'h0);
    chk({31'h0, ph1}, 32'h0);
    $display("reset test done");
    foreach (rows[i]) begin
      apb(1, rows[i].a, rows[i].d);
      chk({31'h0, e}, {31'h0, rows[i].er});
      apb(0, rows[i].a, 0);
      chk(rd, rows[i].x);
    end
    $display("register table done");
    // stopped while the values land, so no zero-length period runs
    apb(1, OFS_CTRL, 32'h6);
    apb(1, OFS_CYCLE, 32'h9);
    apb(1, OFS_DUTY_U, 32'h3);
    apb(1, OFS_DUTY_V, 32'h5);
    apb(1, OFS_DUTY_W, 32'h7);
    apb(1, OFS_CTRL, 32'h7);
    meas(100, 30, 50, 70);
    $display("anytime test done");
    // plain batch: let any old pending transfer pass first
    apb(1, OFS_CTRL, 32'h1);
    cyc(30);
    apb(0, OFS_STATUS, 0);
    apb(1, OFS_MASK, 32'h4);
    apb(1, OFS_DUTY_V, 32'h2);
    meas(100, 30, 50, 70);
    chk({31'h0, irq}, 32'h0);
    apb(1, OFS_DUTY_V, 32'h4);
    apb(1, OFS_DUTY_U, 32'h6);
    cyc(12);
    chk({31'h0, irq}, 32'h1);
    apb(0, OFS_STATUS, 0);
    chk(rd, 32'h4);
    cyc(2);
    chk({31'h0, irq}, 32'h0);
    meas(100, 60, 40, 70);
    chk(na, 32'ha);
    chk(nb, 32'ha);
    $display("batch test done");
    // culled batch: one crest in four, found by polling the status
    apb(1, OFS_CTRL, 32'h3);
    apb(1, OFS_THIN, 32'h23);
    apb(1, OFS_CTRL, 32'h5);
    rd = 0;
    n = 0;
    while (rd[0] !== 1'b1 && n < 30) begin
      apb(0, OFS_STATUS, 0);
      n++;
    end
    chk({31'h0, rd[0]}, 32'h1);
    apb(1, OFS_DUTY_U, 32'h8);
    cyc(20);
    apb(0, OFS_STATUS, 0);
    chk(rd, 32'h0);
    cyc(25);
    apb(0, OFS_STATUS, 0);
    chk(rd, 32'h5);
    meas(100, 80, 40, 70);
    $display("culled test done");
    // each edge code over three pulses of the event input
    for (int c = 0; c < 4; c++) begin
      apb(1, OFS_EDGE, {28'h0, c[1:0], 2'h0});
      apb(1, OFS_EVENTS, 0);
      repeat (3) begin
        evt <= 1;
        cyc(2);
        evt <= 0;
        cyc(2);
      end
      cyc(3);
      apb(0, OFS_EVENTS, 0);
      chk(rd, ev_x[c]);
    end
    $display("edge test done");
    // rising trigger edge restarts the count; read lands two edges later
    apb(1, OFS_EDGE, 32'h1);
    trg <= 1;
    apb(0, OFS_COUNT, 0);
    chk(rd, 32'h1);
    $display("trigger test done");
    summarize();
  end
endmodule
